// ---- include/csc_defs.vh ----
`ifndef CSC_DEFS_VH
`define CSC_DEFS_VH

// Register byte offsets
`define CSC_OFF_CTRL      12'h000
`define CSC_OFF_FORCE     12'h004
`define CSC_OFF_CHG_LIM   12'h008
`define CSC_OFF_IN_LIM    12'h00c
`define CSC_OFF_REV_LIM   12'h010
`define CSC_OFF_STATE     12'h014
`define CSC_OFF_IRQ_STAT  12'h018
`define CSC_OFF_IRQ_MASK  12'h01c
`define CSC_OFF_EFF_LIM   12'h020

// Control register fields
`define CSC_CTRL_CHG_ALLOW     0
`define CSC_CTRL_STAT_OFF      1
`define CSC_CTRL_SUPPLY_OFF    2
`define CSC_CTRL_CHGPIN_OFF    3
`define CSC_CTRL_CHGLIM_ON     4
`define CSC_CTRL_INLIM_ON      5
`define CSC_CTRL_REVERSE       6
`define CSC_CTRL_RST           7'h31

// Status register fields
`define CSC_ST_CHARGING   0
`define CSC_ST_SUPPLY_OK  1
`define CSC_ST_TEMP_OK    2
`define CSC_ST_HIZ        3
`define CSC_ST_CE_PIN     4
`define CSC_ST_CHG_DONE   5

// Interrupt event bits
`define CSC_EV_CHARGING   0
`define CSC_EV_SUPPLY     1
`define CSC_EV_TEMP       2
`define CSC_EV_HIZ        3
`define CSC_EV_W          4

// Interrupt pulse width: 256 us
`define CSC_INT_PULSE_NS  256000
`define CSC_CLK_PERIOD_NS 25
`define CSC_INT_PULSE_CYC (`CSC_INT_PULSE_NS / `CSC_CLK_PERIOD_NS)

`endif

// ---- logic/csc_status_pins.v ----
// Overview of operation
// - Event pulses interrupt pin low 256 us
// - Status-off bit stops charge status outputs
// - Disabled status outputs follow own force bits
// - Supply-good low only inside voltage window
// - Supply-good off bit selects force bit c
// - Charge needs allow bit and pin low
// - Charge-pin off: ignore pin, drive force d
// - Thermistor out of window suspends charging
// - Charge limit is smaller of pin, register
// - Reverse: pin limits discharge, register kept
// - Pin enable zero ignores charge limit pin
// - High input limit pin enters high impedance
// - Input limit is smaller of pin, register
// - Input pin enable zero ignores pin, hiz
// - Charging ties divider return to ground
// - Supply outside window floats divider return
// - Undervolt low or overvolt high stops charge
//
// The APB register port and the register offsets are this design's own decisions.
`include "csc_defs.vh"

module csc_status_pins #(
    parameter LW        = 12,
    parameter PULSE_CYC = `CSC_INT_PULSE_CYC
) (
    input  wire          pclk,             // APB clock, 40 MHz
    input  wire          presetn,          // Async reset, active low
    input  wire          psel,             // APB select
    input  wire          penable,          // APB access phase
    input  wire          pwrite,           // APB write
    input  wire [11:0]   paddr,            // APB byte address
    input  wire [31:0]   pwdata,           // APB write data
    output reg  [31:0]   prdata,           // APB read data
    output reg           pready,           // APB ready
    output reg           pslverr,          // APB error
    input  wire          undervolt_cmp,    // High: above undervolt ref
    input  wire          overvolt_cmp,     // High: above overvolt ref
    input  wire          thermistor_in,    // High: temperature in window
    input  wire          charge_done,      // High: charge cycle finished
    input  wire [LW-1:0] charge_limit_pin, // Pin charge limit code
    input  wire          input_limit_pin,  // Input pin pulled high
    input  wire [LW-1:0] input_limit_code, // Pin input limit code
    input  wire          charge_en_n_i,    // Charge enable pin level
    output reg           charge_en_n_o,    // Charge enable pin drive
    output reg           charge_en_n_oe_n, // Pin drive enable, low
    output reg           int_n_oe_n,       // Interrupt pull, low active
    output reg           status_out_a_oe_n,// Status a pull, low active
    output reg           status_out_b_oe_n,// Status b pull, low active
    output reg           supply_good_n_oe_n,// Supply good pull, low
    output reg           divider_return_oe_n,// Return to ground, low
    output reg           charge_on,        // Charger enabled
    output reg           high_impedance_mode, // Hiz mode active
    output reg  [LW-1:0] eff_charge_limit, // Effective charge limit
    output reg  [LW-1:0] eff_input_limit,  // Effective input limit
    output reg  [LW-1:0] eff_discharge_limit, // Reverse discharge limit
    output reg           irq                // Level interrupt
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    wire [4:0] raw = {charge_en_n_i, input_limit_pin, thermistor_in,
                      overvolt_cmp, undervolt_cmp};

    // Idle pin levels: enable pin high, temperature good, hiz pulled down
    localparam [4:0] SYNC_RST = 5'h14;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    wire uv_ok   = sync2_q[0];
    wire ov_high = sync2_q[1];
    wire temp_ok = sync2_q[2];
    wire ilim_hi = sync2_q[3];
    wire ce_pin  = sync2_q[4];

    ////////////////////////////////////////////////////////////////////
    // Registers

    reg  [6:0]    ctrl_q;
    reg  [3:0]    force_q;
    reg  [LW-1:0] charge_limit_reg;
    reg  [LW-1:0] input_limit_reg;
    reg  [LW-1:0] reverse_batt_limit;
    reg  [`CSC_EV_W-1:0] irq_stat_q;
    reg  [`CSC_EV_W-1:0] irq_mask_q;

    wire charge_allow_bit    = ctrl_q[`CSC_CTRL_CHG_ALLOW];
    wire status_pins_off     = ctrl_q[`CSC_CTRL_STAT_OFF];
    wire supply_good_off     = ctrl_q[`CSC_CTRL_SUPPLY_OFF];
    wire charge_pin_off      = ctrl_q[`CSC_CTRL_CHGPIN_OFF];
    wire charge_limit_pin_on = ctrl_q[`CSC_CTRL_CHGLIM_ON];
    wire input_limit_pin_on  = ctrl_q[`CSC_CTRL_INLIM_ON];
    wire reverse_mode        = ctrl_q[`CSC_CTRL_REVERSE];
    wire force_ind_a = force_q[0];
    wire force_ind_b = force_q[1];
    wire force_ind_c = force_q[2];
    wire force_ind_d = force_q[3];

    function [LW-1:0] min_lim;
        input [LW-1:0] a;
        input [LW-1:0] b;
        begin
            min_lim = (a < b) ? a : b;
        end
    endfunction

    // Open drain: a one pulls the pin low
    function od_pull;
        input on;
        begin
            od_pull = !on;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Core decisions

    wire supply_ok = uv_ok && !ov_high;
    wire hiz_d     = input_limit_pin_on && ilim_hi;
    wire ce_low    = charge_pin_off ? 1'b1 : !ce_pin;
    wire chg_d     = charge_allow_bit && ce_low && supply_ok
                     && temp_ok && !hiz_d && !reverse_mode;

    wire [LW-1:0] chg_lim_d = charge_limit_pin_on ?
        min_lim(charge_limit_pin, charge_limit_reg) :
        charge_limit_reg;
    wire [LW-1:0] in_lim_d = input_limit_pin_on ?
        min_lim(input_limit_code, input_limit_reg) :
        input_limit_reg;
    // Pin also bounds discharge; register itself stays untouched
    wire [LW-1:0] dis_lim_d = charge_limit_pin_on ?
        min_lim(charge_limit_pin, reverse_batt_limit) :
        reverse_batt_limit;

    wire [5:0] state = {charge_done, ce_pin, hiz_d, temp_ok,
                        supply_ok, chg_d};

    ////////////////////////////////////////////////////////////////////
    // Event detection and interrupt pulse

    // Pulse sequencer states, one-hot
    localparam [1:0] ST_IDLE  = 2'b01;
    localparam [1:0] ST_PULSE = 2'b10;

    reg  [3:0]  prev_q;
    reg  [1:0]  arm_q;
    reg  [1:0]  pulse_st_q;
    reg  [1:0]  pulse_st_d;
    reg  [31:0] pulse_cnt_q;
    reg  [31:0] pulse_cnt_d;
    wire [3:0]  cur   = {hiz_d, temp_ok, supply_ok, chg_d};
    // No edges until the synchronisers hold real pin levels
    wire        armed = (arm_q == 2'h3);
    wire [3:0]  ev    = armed ? (cur ^ prev_q) : 4'h0;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_q  <= 2'h0;
            prev_q <= 4'h0;
        end else begin
            prev_q <= cur;
            if (!armed) begin
                arm_q <= arm_q + 2'h1;
            end
        end
    end

    always @* begin
        pulse_st_d  = pulse_st_q;
        pulse_cnt_d = pulse_cnt_q;
        case (pulse_st_q)
            ST_IDLE: begin
                if (|ev) begin
                    pulse_st_d  = ST_PULSE;
                    pulse_cnt_d = PULSE_CYC;
                end
            end
            ST_PULSE: begin
                if (pulse_cnt_q > 32'h1) begin
                    pulse_cnt_d = pulse_cnt_q - 32'h1;
                end else begin
                    pulse_st_d  = ST_IDLE;
                    pulse_cnt_d = 32'h0;
                end
            end
            default: begin
                pulse_st_d  = ST_IDLE;
                pulse_cnt_d = 32'h0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_st_q  <= ST_IDLE;
            pulse_cnt_q <= 32'h0;
            int_n_oe_n  <= 1'b1;
        end else begin
            pulse_st_q  <= pulse_st_d;
            pulse_cnt_q <= pulse_cnt_d;
            int_n_oe_n  <= !pulse_st_d[1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave

    wire acc  = psel && penable;
    wire wr   = acc && pwrite;

    // One-hot register select
    function [8:0] reg_sel;
        input [11:0] addr;
        begin
            case (addr)
                `CSC_OFF_CTRL:     reg_sel = 9'h001;
                `CSC_OFF_FORCE:    reg_sel = 9'h002;
                `CSC_OFF_CHG_LIM:  reg_sel = 9'h004;
                `CSC_OFF_IN_LIM:   reg_sel = 9'h008;
                `CSC_OFF_REV_LIM:  reg_sel = 9'h010;
                `CSC_OFF_STATE:    reg_sel = 9'h020;
                `CSC_OFF_IRQ_STAT: reg_sel = 9'h040;
                `CSC_OFF_IRQ_MASK: reg_sel = 9'h080;
                `CSC_OFF_EFF_LIM:  reg_sel = 9'h100;
                default:           reg_sel = 9'h000;
            endcase
        end
    endfunction

    wire [8:0] sel = reg_sel(paddr);
    wire       hit = |sel;
    wire       w1c = wr && sel[6];

    reg [31:0] rd_d;
    always @* begin
        case (paddr)
            `CSC_OFF_CTRL:     rd_d = {25'h0, ctrl_q};
            `CSC_OFF_FORCE:    rd_d = {28'h0, force_q};
            `CSC_OFF_CHG_LIM:  rd_d = {{(32-LW){1'b0}}, charge_limit_reg};
            `CSC_OFF_IN_LIM:   rd_d = {{(32-LW){1'b0}}, input_limit_reg};
            `CSC_OFF_REV_LIM:  rd_d = {{(32-LW){1'b0}}, reverse_batt_limit};
            `CSC_OFF_STATE:    rd_d = {26'h0, state};
            `CSC_OFF_IRQ_STAT: rd_d = {28'h0, irq_stat_q};
            `CSC_OFF_IRQ_MASK: rd_d = {28'h0, irq_mask_q};
            `CSC_OFF_EFF_LIM:  rd_d = {{(32-2*LW){1'b0}}, eff_input_limit,
                                       eff_charge_limit};
            default:           rd_d = 32'h0;
        endcase
    end

    // Zero-wait response: ready in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !hit;
            prdata  <= pwrite ? 32'h0 : rd_d;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q             <= `CSC_CTRL_RST;
            force_q            <= 4'h0;
            charge_limit_reg   <= {LW{1'b1}};
            input_limit_reg    <= {LW{1'b1}};
            reverse_batt_limit <= {LW{1'b1}};
            irq_mask_q         <= 4'h0;
        end else if (wr && pready) begin
            case (paddr)
                `CSC_OFF_CTRL:     ctrl_q <= pwdata[6:0];
                `CSC_OFF_FORCE:    force_q <= pwdata[3:0];
                `CSC_OFF_CHG_LIM:  charge_limit_reg <= pwdata[LW-1:0];
                `CSC_OFF_IN_LIM:   input_limit_reg <= pwdata[LW-1:0];
                `CSC_OFF_REV_LIM:  reverse_batt_limit <= pwdata[LW-1:0];
                `CSC_OFF_IRQ_MASK: irq_mask_q <= pwdata[3:0];
                default:           ctrl_q <= ctrl_q;
            endcase
        end
    end

    // Sticky events; a new event wins over a same-cycle clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 4'h0;
        end else begin
            irq_stat_q <= (irq_stat_q &
                           ~((w1c && pready) ? pwdata[3:0] : 4'h0)) | ev;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drivers, open drain: oe_n low pulls the pin low

    // Charge status pins or software indicators
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_out_a_oe_n <= 1'b1;
            status_out_b_oe_n <= 1'b1;
        end else if (status_pins_off) begin
            status_out_a_oe_n <= od_pull(force_ind_a);
            status_out_b_oe_n <= od_pull(force_ind_b);
        end else begin
            status_out_a_oe_n <= !chg_d;
            status_out_b_oe_n <= !charge_done;
        end
    end

    // Supply good, charge enable and divider return pins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_good_n_oe_n  <= 1'b1;
            divider_return_oe_n <= 1'b1;
            charge_en_n_o       <= 1'b0;
            charge_en_n_oe_n    <= 1'b1;
        end else begin
            supply_good_n_oe_n <= supply_good_off ?
                                  od_pull(force_ind_c) : !supply_ok;
            charge_en_n_o    <= 1'b0;
            charge_en_n_oe_n <= od_pull(charge_pin_off && force_ind_d);
            // Ground only while charging; float outside window
            divider_return_oe_n <= !(chg_d && supply_ok);
        end
    end

    // Charger state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge_on           <= 1'b0;
            high_impedance_mode <= 1'b0;
        end else begin
            charge_on           <= chg_d;
            high_impedance_mode <= hiz_d;
        end
    end

    // Effective limits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_charge_limit    <= {LW{1'b0}};
            eff_input_limit     <= {LW{1'b0}};
            eff_discharge_limit <= {LW{1'b0}};
        end else begin
            eff_charge_limit    <= chg_lim_d;
            eff_input_limit     <= in_lim_d;
            eff_discharge_limit <= reverse_mode ? dis_lim_d
                                                : reverse_batt_limit;
        end
    end

endmodule

// ---- tb/csc_props.sv ----
module csc_props #(
    parameter PULSE_CYC = 8
) (
    input wire pclk,                // Clock
    input wire presetn,             // Reset, low
    input wire psel,                // Select
    input wire penable,             // Access
    input wire pready,              // Ready
    input wire undervolt_cmp,       // Above low ref
    input wire overvolt_cmp,        // Above high ref
    input wire thermistor_in,       // Temp in window
    input wire int_n_oe_n,          // Interrupt pull
    input wire divider_return_oe_n, // Return tie
    input wire charge_on,           // Charging
    input wire high_impedance_mode  // Hiz
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] low_q;
    logic [15:0] low_d;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    // Length of the running low pulse
    assign low_d = int_n_oe_n ? 16'h0000 :
                   (low_q == 16'(PULSE_CYC)) ? 16'h0001 : low_q + 16'h0001;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            low_q <= 16'h0000;
        else
            low_q <= low_d;
    end
    ////////////////////////////////////////
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_ready_once;
        pready |=> !pready;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("long ready");
    property p_int_len;
        int_n_oe_n && low_q != 16'h0000 |-> low_q == 16'(PULSE_CYC);
    endproperty
    a_int_len: assert property (p_int_len) else $error("pulse length");
    property p_uv;
        !undervolt_cmp [*4] |-> !charge_on;
    endproperty
    a_uv: assert property (p_uv) else $error("charging below window");
    property p_ov;
        overvolt_cmp [*4] |-> !charge_on;
    endproperty
    a_ov: assert property (p_ov) else $error("charging above window");
    property p_temp;
        !thermistor_in [*4] |-> !charge_on;
    endproperty
    a_temp: assert property (p_temp) else $error("charging out of temp");
    property p_div;
        !undervolt_cmp [*4] |-> divider_return_oe_n;
    endproperty
    a_div: assert property (p_div) else $error("return tied");
    property p_hiz;
        high_impedance_mode [*2] |-> !charge_on;
    endproperty
    a_hiz: assert property (p_hiz) else $error("charging in hiz");
endmodule

// ---- tb/csc_host.sv ----
module csc_host (
    input wire int_n_oe_n,       // Interrupt pull
    input wire charge_en_n_o,    // Device level
    input wire charge_en_n_oe_n, // Device drive, low
    input wire ce_level,         // Host level
    input wire hiz_req,          // Host asks hiz
    output logic int_n,          // Interrupt wire
    output logic ce_pin,         // Enable wire
    output logic hiz_pin         // Limit pin wire
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up when released
    assign int_n = int_n_oe_n ? 1'b1 : 1'b0;
    // Host lets go once the device drives
    assign ce_pin = charge_en_n_oe_n ? ce_level : charge_en_n_o;
    assign hiz_pin = hiz_req;
endmodule

// ---- tb/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PULSE = 8;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, rerr, irq, charge_on;
    logic        undervolt_cmp = 1'b1, overvolt_cmp = 1'b0;
    logic        thermistor_in = 1'b1, charge_done = 1'b0;
    logic        ce_level = 1'b0, hiz_req = 1'b0, ce_pin, hiz_pin;
    logic [11:0] charge_limit_pin = 12'h100, input_limit_code = 12'h200;
    logic [11:0] eff_charge_limit, eff_input_limit, eff_discharge_limit;
    logic        charge_en_n_o, charge_en_n_oe_n, int_n_oe_n, int_n;
    logic        status_out_a_oe_n, status_out_b_oe_n, high_impedance_mode;
    logic        supply_good_n_oe_n, divider_return_oe_n;
    logic [6:0]  pins;
    int          num_errors = 0, comparisons = 0, n;
    assign pins = {status_out_a_oe_n, status_out_b_oe_n, supply_good_n_oe_n,
                   charge_en_n_oe_n, divider_return_oe_n,
                   high_impedance_mode, charge_on};
    always #12.5 pclk = ~pclk;
    csc_status_pins #(.PULSE_CYC(PULSE)) dut_u (
        .charge_en_n_i   (ce_pin),
        .input_limit_pin (hiz_pin),
        .*
    );
    csc_host host_u (.*);
    ////////////////////////////////////////
    task automatic end_sim;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20) begin
            num_errors++;
            end_sim();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [39:0] e);
        apb(1'b0, a, 32'h0);
        chk({7'h0, rerr, rdat}, e);
    endtask
    task automatic settle;
        repeat (6) @(posedge pclk);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        settle();
        rd(12'h000, 40'h31);
        rd(12'h010, 40'hfff);
        rd(12'h01c, 40'h0);
        rd(12'h024, 40'h0100000000);
        chk(pins, 40'h29);
        chk({eff_input_limit, eff_charge_limit}, 40'h200100);
        $display("test reset done");
        apb(1'b1, 12'h008, 32'h80);
        chk(eff_charge_limit, 40'h80);
        apb(1'b1, 12'h008, 32'h300);
        chk(eff_charge_limit, 40'h100);
        apb(1'b1, 12'h000, 32'h21);
        chk(eff_charge_limit, 40'h300);
        apb(1'b1, 12'h00c, 32'h50);
        chk(eff_input_limit, 40'h50);
        apb(1'b1, 12'h000, 32'h71);
        settle();
        chk({eff_discharge_limit, charge_on}, 40'h200);
        rd(12'h010, 40'hfff);
        $display("test limits done");
        apb(1'b1, 12'h000, 32'h31);
        hiz_req <= 1'b1;
        settle();
        chk({high_impedance_mode, charge_on}, 40'h2);
        apb(1'b1, 12'h000, 32'h11);
        settle();
        chk({eff_input_limit, high_impedance_mode, charge_on}, 40'h141);
        hiz_req <= 1'b0;
        apb(1'b1, 12'h000, 32'h31);
        ce_level <= 1'b1;
        settle();
        chk(charge_on, 40'h0);
        ce_level <= 1'b0;
        apb(1'b1, 12'h000, 32'h30);
        settle();
        chk(charge_on, 40'h0);
        apb(1'b1, 12'h000, 32'h39);
        ce_level <= 1'b1;
        apb(1'b1, 12'h004, 32'h8);
        settle();
        chk({charge_en_n_oe_n, charge_on}, 40'h1);
        apb(1'b1, 12'h004, 32'h0);
        chk({charge_en_n_oe_n, charge_on}, 40'h3);
        ce_level <= 1'b0;
        apb(1'b1, 12'h000, 32'h37);
        apb(1'b1, 12'h004, 32'h1);
        chk(pins[6:4], 40'h3);
        apb(1'b1, 12'h004, 32'h6);
        chk(pins[6:4], 40'h4);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h000, 32'h31);
        $display("test pins done");
        settle();
        apb(1'b1, 12'h018, 32'hf);
        undervolt_cmp <= 1'b0;
        settle();
        chk({irq, pins}, 40'h7c);
        rd(12'h018, 40'h3);
        apb(1'b1, 12'h018, 32'h3);
        rd(12'h018, 40'h0);
        chk(irq, 40'h0);
        overvolt_cmp <= 1'b1;
        undervolt_cmp <= 1'b1;
        settle();
        chk(charge_on, 40'h0);
        overvolt_cmp <= 1'b0;
        repeat (30) @(posedge pclk);
        apb(1'b1, 12'h018, 32'hf);
        apb(1'b1, 12'h01c, 32'h5);
        thermistor_in <= 1'b0;
        for (n = 0; n < 30 && int_n !== 1'b0; n++)
            @(posedge pclk);
        for (n = 0; n < 30 && int_n === 1'b0; n++)
            @(posedge pclk);
        chk(n, PULSE);
        rd(12'h018, 40'h5);
        chk({irq, charge_on}, 40'h2);
        apb(1'b1, 12'h01c, 32'h0);
        chk(irq, 40'h0);
        $display("test interrupt done");
        end_sim();
    end
endmodule

bind csc_status_pins csc_props #(.PULSE_CYC(PULSE_CYC)) prop_u (.*);
